// ### inc/pump_cfg.svh
// Timing constants and switch positions for the pump run-permission block.
// Assumes a single 10 MHz system clock; included by bare name.
`ifndef PUMP_CFG_SVH
`define PUMP_CFG_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SECOND_NS 1000000000
`define TICK_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Delay lengths in minutes and seconds
// ----------------------------------------------------------------------------
`define DEFAULT_DELAY_MIN 3
`define LONG_DELAY_MIN 10
`define LONGEST_DELAY_MIN 30
`define STRETCH_LIMIT_MIN 14
`define OVERCURRENT_HOLD_MIN 3
`define SECONDS_PER_MIN 60
`define DEFAULT_DELAY_S (`DEFAULT_DELAY_MIN * `SECONDS_PER_MIN)
`define LONG_DELAY_S (`LONG_DELAY_MIN * `SECONDS_PER_MIN)
`define LONGEST_DELAY_S (`LONGEST_DELAY_MIN * `SECONDS_PER_MIN)
`define STRETCH_LIMIT_S (`STRETCH_LIMIT_MIN * `SECONDS_PER_MIN)
`define OVERCURRENT_HOLD_S (`OVERCURRENT_HOLD_MIN * `SECONDS_PER_MIN)
`define SCREEN_INTERVAL_S 4

// ----------------------------------------------------------------------------
// Configuration switch positions (bit 0 is switch 1)
// ----------------------------------------------------------------------------
`define SW_REMOTE_POL 0
`define SW_WATER_POL 1
`define SW_DELAY_10 2
`define SW_DELAY_30 3
`define SW_FREEZE 6

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SECONDS_W 12
`define DIV_W 24
`define SCREEN_W 3

`endif

// ### inc/pump_pkg.sv
// Types shared by the pump run-permission block.
// Assumes pump_cfg.svh is on the include path.
`include "pump_cfg.svh"

package pump_pkg;

  // ----------------------------------------------------------------------------
  // Over-current hold-off states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OC_IDLE  = 2'b00,
    OC_HOLD  = 2'b01,
    OC_RETRY = 2'b10
  } oc_state_type;

  // ----------------------------------------------------------------------------
  // Display screens
  // ----------------------------------------------------------------------------
  typedef enum logic [`SCREEN_W-1:0] {
    SCR_STARTUP = 3'h0,
    SCR_STATUS  = 3'h1,
    SCR_INPUT   = 3'h2,
    SCR_SPEED   = 3'h3,
    SCR_DUTY    = 3'h4,
    SCR_POWER   = 3'h5
  } screen_type;

endpackage : pump_pkg

// ### verilog/tick_divider.sv
// One-cycle enable pulse every CYCLES clocks.
// Assumes one free-running system clock.
`timescale 1ns/1ps
`include "pump_cfg.svh"

module tick_divider #(
  parameter int CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  logic [`DIV_W-1:0] count_reg;
  logic [`DIV_W-1:0] count_next;
  logic tick_next;

  always_comb begin
    if (count_reg == `DIV_W'(CYCLES - 1)) begin
      count_next = '0;
      tick_next = 1'b1;
    end else begin
      count_next = count_reg + `DIV_W'(1);
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= tick_next;
    end
  end

endmodule : tick_divider

// ### verilog/second_countdown.sv
// Countdown in whole seconds, held at its load value while load is high.
// Assumes tick is a one-cycle pulse once a second.
`timescale 1ns/1ps
`include "pump_cfg.svh"

module second_countdown (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [`SECONDS_W-1:0] load_value,
  output logic busy,
  output logic done
);

  logic [`SECONDS_W-1:0] count_reg;
  logic [`SECONDS_W-1:0] count_next;
  logic done_next;

  always_comb begin
    count_next = count_reg;
    done_next = 1'b0;
    if (load) begin
      count_next = load_value;
    end else if (tick && count_reg != '0) begin
      count_next = count_reg - `SECONDS_W'(1);
      done_next = (count_reg == `SECONDS_W'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      done <= 1'b0;
    end else begin
      count_reg <= count_next;
      done <= done_next;
    end
  end

  assign busy = (count_reg != '0);

endmodule : second_countdown

// ### verilog/pump_interlock_restart_timer.sv
// Run permission, restart delay, over-current retry and display stepping
// for a solar pump motor controller.
// Assumes all inputs are synchronous to clk and contact inputs are debounced.
// Outputs are registered and follow their cause one clock later.
//
// How it works
// - Switch1 off: remote closed stops pump
// - Switch1 on: remote closed needed to run
// - Switch2 selects water probe polarity likewise
// - Probe wet: off until dry plus delay
// - One delay timer serves both stop inputs
// - No delay switch: default delay, parameterised
// - Switch3 ten minutes, switch4 thirty minutes
// - Hold-off may stretch up to fourteen minutes
// - Over-current switches the pump off
// - Over-current: three minutes off, then retry
// - Over-current lights error, shows message
// - Retries repeat without limit
// - Switch7 off: screens step at fixed interval
// - Switch7 on: display holds current screen
// - Switch7 on at power-up: start-up screen only
`timescale 1ns/1ps
`include "pump_cfg.svh"

module pump_interlock_restart_timer
  import pump_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DEFAULT_DELAY_S = `DEFAULT_DELAY_S
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_switch,
  input wire logic [7:0] config_switch,
  input wire logic remote_contact_input,
  input wire logic water_probe_input,
  input wire logic over_current,
  output logic pump_run,
  output logic remote_stop_indicator,
  output logic error_indicator,
  output logic over_current_message,
  output logic [`SCREEN_W-1:0] screen_select
);

  // ----------------------------------------------------------------------------
  // Second tick
  // ----------------------------------------------------------------------------
  // One shared enable: every timer counts whole seconds, so the first
  // second of any delay may fall short by up to one tick period.
  logic sec_tick;

  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_sec_divider (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sec_tick)
  );

  // ----------------------------------------------------------------------------
  // Contact qualification
  // ----------------------------------------------------------------------------
  // Contact inputs are high while the terminal is shorted to ground.
  // A broken wire reads as open, which runs the pump with switch 1 off.
  logic remote_stop;
  logic water_stop;
  logic stop_active;

  always_comb begin
    if (config_switch[`SW_REMOTE_POL]) begin
      remote_stop = !remote_contact_input;
    end else begin
      remote_stop = remote_contact_input;
    end
    if (config_switch[`SW_WATER_POL]) begin
      water_stop = !water_probe_input;
    end else begin
      water_stop = water_probe_input;
    end
    stop_active = remote_stop || water_stop;
  end

  // ----------------------------------------------------------------------------
  // Restart delay length
  // ----------------------------------------------------------------------------
  // A stop that returns while the delay is still running lengthens the next
  // delay by one default step, capped, so a chattering float cannot hammer
  // the motor. Only the default setting stretches; the long settings do not.
  // The stretched length is capped at fourteen minutes.
  logic [`SECONDS_W-1:0] base_delay;
  logic [`SECONDS_W-1:0] stretch_reg;
  logic [`SECONDS_W-1:0] stretch_next;
  logic [`SECONDS_W:0] stretch_sum;
  logic stop_seen_reg;
  logic stop_seen_next;
  logic delay_busy;
  logic delay_done;
  logic stop_rise;

  always_comb begin
    // Switch 4 wins when both long settings are on.
    if (config_switch[`SW_DELAY_30]) begin
      base_delay = `SECONDS_W'(`LONGEST_DELAY_S);
    end else if (config_switch[`SW_DELAY_10]) begin
      base_delay = `SECONDS_W'(`LONG_DELAY_S);
    end else begin
      base_delay = `SECONDS_W'(DEFAULT_DELAY_S);
    end
  end

  always_comb begin
    stop_rise = stop_active && !stop_seen_reg;
    stop_seen_next = stop_active;
    stretch_sum = {1'b0, stretch_reg} + {1'b0, `SECONDS_W'(DEFAULT_DELAY_S)};
    stretch_next = stretch_reg;
    if (config_switch[`SW_DELAY_30] || config_switch[`SW_DELAY_10]) begin
      stretch_next = base_delay;
    end else if (stop_rise && delay_busy) begin
      if (stretch_sum > {1'b0, `SECONDS_W'(`STRETCH_LIMIT_S)}) begin
        stretch_next = `SECONDS_W'(`STRETCH_LIMIT_S);
      end else begin
        stretch_next = stretch_sum[`SECONDS_W-1:0];
      end
    end else if (delay_done || stretch_reg < base_delay) begin
      stretch_next = base_delay;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= '0;
      stop_seen_reg <= 1'b0;
    end else begin
      stretch_reg <= stretch_next;
      stop_seen_reg <= stop_seen_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Shared restart delay timer
  // ----------------------------------------------------------------------------
  // Held loaded while any stop is present; it counts only once the stop clears.
  // Reloading on every stop means a brief contact bounce restarts the delay.
  second_countdown u_restart_delay (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sec_tick),
    .load(stop_active),
    .load_value(stretch_next),
    .busy(delay_busy),
    .done(delay_done)
  );

  // ----------------------------------------------------------------------------
  // Over-current hold-off
  // ----------------------------------------------------------------------------
  // The hold is 180 whole seconds; the tick phase makes it up to one second
  // shorter than that, never longer.
  oc_state_type oc_state_reg;
  oc_state_type oc_state_next;
  logic oc_load;
  logic oc_busy;
  logic oc_done;
  logic error_next;
  logic oc_message_next;

  second_countdown u_oc_hold (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sec_tick),
    .load(oc_load),
    .load_value(`SECONDS_W'(`OVERCURRENT_HOLD_S)),
    .busy(oc_busy),
    .done(oc_done)
  );

  always_comb begin
    oc_state_next = oc_state_reg;
    oc_load = 1'b0;
    case (oc_state_reg)
      OC_IDLE: begin
        if (over_current && pump_run) begin
          oc_state_next = OC_HOLD;
          oc_load = 1'b1;
        end
      end
      OC_HOLD: begin
        // Not busy also catches a hold that never got its load.
        if (oc_done || !oc_busy) begin
          oc_state_next = OC_RETRY;
        end
      end
      OC_RETRY: begin
        // A retry that trips again re-enters the hold, any number of times.
        if (over_current && pump_run) begin
          oc_state_next = OC_HOLD;
          oc_load = 1'b1;
        end else if (pump_run) begin
          // A clean start ends the retry.
          oc_state_next = OC_IDLE;
        end
      end
      default: begin
        oc_state_next = OC_IDLE;
      end
    endcase
    // Indicator and message are not latched; both drop when the hold ends.
    error_next = (oc_state_next == OC_HOLD);
    oc_message_next = (oc_state_next == OC_HOLD);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_state_reg <= OC_IDLE;
      error_indicator <= 1'b0;
      over_current_message <= 1'b0;
    end else begin
      oc_state_reg <= oc_state_next;
      error_indicator <= error_next;
      over_current_message <= oc_message_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Run permission
  // ----------------------------------------------------------------------------
  // Switches 5, 6 and 8 are expected off and are not looked at.
  logic run_next;
  logic stop_ind_next;

  // Over-current is left out of the terms on purpose: a retry has to start
  // the motor so that a current still above the limit trips the hold again.
  always_comb begin
    run_next = run_switch;
    if (stop_active || delay_busy) begin
      run_next = 1'b0;
    end
    if (oc_state_next == OC_HOLD) begin
      run_next = 1'b0;
    end
    stop_ind_next = stop_active || delay_busy;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_run <= 1'b0;
      remote_stop_indicator <= 1'b0;
    end else begin
      pump_run <= run_next;
      remote_stop_indicator <= stop_ind_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Display stepping
  // ----------------------------------------------------------------------------
  // The start-up screen shows after reset for one interval, then the status
  // screens rotate. Freezing at power-up pins the start-up screen.
  // Freezing stops the interval timer too, so the phase resumes where it left.
  // Only screens 1 to 5 rotate; the start-up screen is never revisited.
  logic [`SECONDS_W-1:0] screen_timer_reg;
  logic [`SECONDS_W-1:0] screen_timer_next;
  logic [`SCREEN_W-1:0] screen_next;
  logic startup_hold_reg;
  logic startup_hold_next;
  logic freeze;

  always_comb begin
    freeze = config_switch[`SW_FREEZE];
    startup_hold_next = startup_hold_reg && freeze;
    screen_timer_next = screen_timer_reg;
    screen_next = screen_select;
    if (startup_hold_reg) begin
      screen_next = SCR_STARTUP;
      screen_timer_next = '0;
    end else if (!freeze && sec_tick) begin
      if (screen_timer_reg == `SECONDS_W'(`SCREEN_INTERVAL_S - 1)) begin
        screen_timer_next = '0;
        if (screen_select == SCR_POWER) begin
          screen_next = SCR_STATUS;
        end else begin
          screen_next = screen_select + `SCREEN_W'(1);
        end
      end else begin
        screen_timer_next = screen_timer_reg + `SECONDS_W'(1);
      end
    end
    // Frozen: neither timer nor screen move.
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      screen_timer_reg <= '0;
      screen_select <= SCR_STARTUP;
      startup_hold_reg <= 1'b1;
    end else begin
      screen_timer_reg <= screen_timer_next;
      screen_select <= screen_next;
      startup_hold_reg <= startup_hold_next;
    end
  end

endmodule : pump_interlock_restart_timer

// ### dv/pump_interlock_assertions.sv
// Checker for the pump run-permission block, watching its ports only.
// Assumes a single clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "pump_cfg.svh"

module pump_interlock_assertions #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_switch,
  input wire logic [7:0] config_switch,
  input wire logic remote_contact_input,
  input wire logic water_probe_input,
  input wire logic over_current,
  input wire logic pump_run,
  input wire logic remote_stop_indicator,
  input wire logic error_indicator,
  input wire logic over_current_message,
  input wire logic [`SCREEN_W-1:0] screen_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------------------
  // Hold length counter
  // ----------------------------------------------------------------------------
  int hold_reg;
  int hold_next;
  always_comb begin
    hold_next = error_indicator ? hold_reg + 1 : 0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 0;
    end else begin
      hold_reg <= hold_next;
    end
  end
  logic remote_stop;
  logic water_stop;
  assign remote_stop = remote_contact_input ^ config_switch[`SW_REMOTE_POL];
  assign water_stop = water_probe_input ^ config_switch[`SW_WATER_POL];
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  a_remote_stops_pump: assert property (remote_stop |=> !pump_run) else $error("pump ran on remote stop");
  a_water_stops_pump: assert property (water_stop |=> !pump_run) else $error("pump ran on probe stop");
  a_stop_shows_indicator: assert property ((remote_stop || water_stop) |=> remote_stop_indicator)
    else $error("stop indicator missing");
  a_run_switch_off: assert property (!run_switch |=> !pump_run) else $error("pump ran while switched off");
  a_run_clean: assert property (pump_run |-> !remote_stop_indicator && !error_indicator)
    else $error("pump ran during hold-off");
  a_trip_on_current: assert property (pump_run && over_current |=> !pump_run && error_indicator)
    else $error("over-current did not trip");
  a_message_pair: assert property (error_indicator == over_current_message) else $error("message mismatch");
  a_hold_length: assert property ($fell(error_indicator) |->
    hold_reg >= 179 * TICK_CYCLES && hold_reg <= 181 * TICK_CYCLES + 2) else $error("hold length wrong");
  a_screen_frozen: assert property (config_switch[`SW_FREEZE] |=> $stable(screen_select))
    else $error("screen moved while frozen");
  a_screen_step: assert property ($changed(screen_select) |-> screen_select ==
    (($past(screen_select) == 3'h5) ? 3'h1 : $past(screen_select) + 3'h1)) else $error("screen order wrong");
endmodule : pump_interlock_assertions

// ### dv/contact_model.sv
// Remote float switch and water probe seen from the controller terminals.
// Assumes the bench commands the contact state; slow adds a settling lag.
`timescale 1ns/1ps

module contact_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic remote_closed,
  input wire logic probe_wet,
  input wire logic slow,
  output logic remote_contact_input,
  output logic water_probe_input
);
  logic [3:0] lag_reg;
  logic [3:0] lag_next;
  logic [3:0] wet_reg;
  logic [3:0] wet_next;
  always_comb begin
    lag_next = {lag_reg[2:0], remote_closed};
    wet_next = {wet_reg[2:0], probe_wet};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lag_reg <= 4'h0;
      wet_reg <= 4'h0;
    end else begin
      lag_reg <= lag_next;
      wet_reg <= wet_next;
    end
  end
  // A slow contact reaches its new level only after four clocks
  assign remote_contact_input = slow ? lag_reg[3] : remote_closed;
  assign water_probe_input = slow ? wet_reg[3] : probe_wet;
endmodule : contact_model

// ### dv/testbench.sv
// Self-checking bench for the pump run-permission block.
// Assumes a 10 MHz clock and a shortened second for reasonable run time.
`timescale 1ns/1ps
`include "pump_cfg.svh"

module testbench;
  import pump_pkg::*;
  localparam int T = 10;
  localparam int D = 3;
  logic clk, rst_n, run_switch, rem, wet, slow, over_current;
  logic [7:0] config_switch;
  logic remote_contact_input, water_probe_input, pump_run;
  logic remote_stop_indicator, error_indicator, over_current_message;
  logic [`SCREEN_W-1:0] screen_select;
  int fails, total_checks, n;
  pump_interlock_restart_timer #(.TICK_CYCLES(T), .DEFAULT_DELAY_S(D)) u_pump_interlock_restart_timer (
    .clk(clk), .rst_n(rst_n), .run_switch(run_switch), .config_switch(config_switch),
    .remote_contact_input(remote_contact_input), .water_probe_input(water_probe_input),
    .over_current(over_current), .pump_run(pump_run), .remote_stop_indicator(remote_stop_indicator),
    .error_indicator(error_indicator), .over_current_message(over_current_message),
    .screen_select(screen_select));
  contact_model u_contact_model (.clk(clk), .rst_n(rst_n), .remote_closed(rem), .probe_wet(wet),
    .slow(slow), .remote_contact_input(remote_contact_input), .water_probe_input(water_probe_input));
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic probe(input int sel);
    case (sel)
      0: probe = pump_run;
      1: probe = error_indicator;
      2: probe = (screen_select === SCR_STATUS);
      default: probe = (screen_select === SCR_INPUT);
    endcase
  endfunction : probe
  // Bounded wait, so a stuck output ends in a mismatch and not a hang
  task automatic wait_for(input int sel, input logic val, input int lim);
    n = 0;
    while (probe(sel) !== val && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_for
  task automatic in_range(input int lo, input int hi);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask : in_range
  task automatic stop_go(input logic [7:0] cfg, input logic rs, ws, rg, wg, input int s);
    config_switch = cfg;
    rem = rs;
    wet = ws;
    tick(8);
    chk(pump_run, 1'b0);
    chk(remote_stop_indicator, 1'b1);
    rem = rg;
    wet = wg;
    wait_for(0, 1'b1, s * T + 50);
    in_range((s - 1) * T, s * T + 10);
    chk(remote_stop_indicator, 1'b0);
  endtask : stop_go
  task automatic do_reset(input logic [7:0] cfg);
    config_switch = cfg;
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
  endtask : do_reset
  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    run_switch = 1'b0;
    config_switch = 8'h00;
    rem = 1'b0;
    wet = 1'b0;
    slow = 1'b0;
    over_current = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(3);
    chk(pump_run, 1'b0);
    run_switch = 1'b1;
    tick(3);
    chk(pump_run, 1'b1);
    stop_go(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, D);
    stop_go(8'h01, 1'b0, 1'b0, 1'b1, 1'b0, D);
    stop_go(8'h00, 1'b0, 1'b1, 1'b0, 1'b0, D);
    stop_go(8'h02, 1'b0, 1'b0, 1'b0, 1'b1, D);
    slow = 1'b1;
    stop_go(8'h00, 1'b1, 1'b0, 1'b0, 1'b0, D);
    slow = 1'b0;
    $display("polarity test done");
    rem = 1'b1;
    tick(3);
    rem = 1'b0;
    tick(5);
    rem = 1'b1;
    tick(3);
    rem = 1'b0;
    wait_for(0, 1'b1, 3 * D * T);
    in_range((2 * D - 1) * T, 2 * D * T + 10);
    stop_go(8'h04, 1'b1, 1'b0, 1'b0, 1'b0, 600);
    stop_go(8'h08, 1'b1, 1'b0, 1'b0, 1'b0, 1800);
    stop_go(8'h0C, 1'b1, 1'b0, 1'b0, 1'b0, 1800);
    config_switch = 8'h00;
    $display("delay test done");
    over_current = 1'b1;
    tick(2);
    chk(pump_run, 1'b0);
    chk(error_indicator, 1'b1);
    chk(over_current_message, 1'b1);
    wait_for(1, 1'b0, 200 * T);
    in_range(179 * T - 2, 181 * T + 2);
    wait_for(1, 1'b1, 10);
    chk(error_indicator, 1'b1);
    over_current = 1'b0;
    wait_for(1, 1'b0, 200 * T);
    wait_for(0, 1'b1, 10);
    chk(pump_run, 1'b1);
    $display("over-current test done");
    do_reset(8'h00);
    wait_for(2, 1'b1, 5 * T);
    in_range(3 * T, 4 * T + 2);
    wait_for(3, 1'b1, 5 * T);
    in_range(4 * T - 2, 4 * T + 2);
    config_switch = 8'h40;
    tick(100);
    chk(screen_select, SCR_INPUT);
    do_reset(8'h40);
    tick(100);
    chk(screen_select, SCR_STARTUP);
    config_switch = 8'h00;
    wait_for(2, 1'b1, 10 * T);
    chk(screen_select, SCR_STATUS);
    $display("display test done");
    results();
  end
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    results();
  end
endmodule : testbench

bind pump_interlock_restart_timer pump_interlock_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .run_switch(run_switch), .config_switch(config_switch),
  .remote_contact_input(remote_contact_input), .water_probe_input(water_probe_input),
  .over_current(over_current), .pump_run(pump_run), .remote_stop_indicator(remote_stop_indicator),
  .error_indicator(error_indicator), .over_current_message(over_current_message),
  .screen_select(screen_select));
